// >>> core/fbr_burst_seq.sv
// The placing of the registers and the AXI4-Lite slave port were decided locally.
`timescale 1ns/10ps
`default_nettype none
module fbr_burst_seq #(
  parameter int ADDR_W = 22,
  parameter int MEM_AW = 10,
  parameter int SEC_AW = 7
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              clk_en,
  // Flash link: controls, address and data in from the host controller, data, drive enable and ready back to it
  input  wire logic              burst_clk,
  input  wire logic              chip_en_n,
  input  wire logic              address_valid_n,
  input  wire logic              out_en_n,
  input  wire logic              write_en_n,
  input  wire logic              flash_reset_n,
  input  wire logic [ADDR_W-17:0] addr_hi_i,
  input  wire logic [15:0]       adq_i,
  output logic      [15:0]       adq_o,
  output logic                   adq_oe_n,
  output logic                   rdy,
  // AXI4-Lite register port
  input  wire logic [7:0]        awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [7:0]        araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready
);

  localparam int NSEC   = 1 << (MEM_AW - SEC_AW);
  localparam int SEC_W  = MEM_AW - SEC_AW;
  localparam int PIN_W  = 6 + (ADDR_W - 16) + 16;

  typedef struct packed {
    fbr_pkg::fbr_state_e st;
    logic [ADDR_W-1:0]   addr;
    logic [ADDR_W-1:0]   cmd_addr;
    logic [2:0]          start_w;
    logic                first;
    logic [3:0]          cnt;
    logic [3:0]          left;
    logic                clk_prev;
    logic [15:0]         dout;
    logic                drive_n;
    logic                rdy;
    logic                prog_arm;
    logic [NSEC-1:0]     ers_pend;
    logic                ers_act;
    logic [SEC_W-1:0]    ers_sec;
    logic [SEC_AW-1:0]   ers_w;
    logic                susp;
    logic                refused;
  } fbr_core_s;

  fbr_core_s s_q;
  fbr_core_s s_d;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [PIN_W-1:0] pin_s;
  logic             clk_s;
  logic             ce_n_s;
  logic             avd_n_s;
  logic             oe_n_s;
  logic             we_n_s;
  logic             frst_n_s;
  logic [ADDR_W-1:0] bus_addr_s;

  // Idle levels at reset keep the engine from seeing a phantom access
  fbr_sync #(
    .W       (PIN_W),
    .RST_VAL ({6'b011111, {(PIN_W - 6){1'b0}}})
  ) u_pin_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .clk_en  (clk_en),
    .d       ({burst_clk, chip_en_n, address_valid_n, out_en_n, write_en_n,
                flash_reset_n, addr_hi_i, adq_i}),
    .q       (pin_s)
  );

  assign clk_s      = pin_s[PIN_W-1];
  assign ce_n_s     = pin_s[PIN_W-2];
  assign avd_n_s    = pin_s[PIN_W-3];
  assign oe_n_s     = pin_s[PIN_W-4];
  assign we_n_s     = pin_s[PIN_W-5];
  assign frst_n_s   = pin_s[PIN_W-6];
  assign bus_addr_s = pin_s[ADDR_W-1:0];

  // ----------------------------------------------------------------
  // Register slave
  // ----------------------------------------------------------------
  logic [15:0] cfg;
  logic        refuse_clr;
  logic [31:0] status_w;

  assign status_w = {27'h0000000, |s_q.ers_pend, s_q.refused, s_q.susp, s_q.ers_act,
                     s_q.st != fbr_pkg::ST_IDLE};

  fbr_axil #(
    .AW (8)
  ) u_axil (
    .aclk         (aclk),
    .aresetn      (aresetn),
    .clk_en       (clk_en),
    .awaddr       (awaddr),
    .awvalid      (awvalid),
    .awready      (awready),
    .wdata        (wdata),
    .wstrb        (wstrb),
    .wvalid       (wvalid),
    .wready       (wready),
    .bresp        (bresp),
    .bvalid       (bvalid),
    .bready       (bready),
    .araddr       (araddr),
    .arvalid      (arvalid),
    .arready      (arready),
    .rdata        (rdata),
    .rresp        (rresp),
    .rvalid       (rvalid),
    .rready       (rready),
    .status_i     (status_w),
    .addr_i       (32'(s_q.addr)),
    .cfg_o        (cfg),
    .refuse_clr_o (refuse_clr)
  );

  // ----------------------------------------------------------------
  // Array storage
  // ----------------------------------------------------------------
  // Single write port shared by program and the erase sweep; the read
  // side is separate, so reads never wait on either (zero latency)
  logic [15:0]       mem [0:(1 << MEM_AW)-1];
  logic              mem_we;
  logic [MEM_AW-1:0] mem_wa;
  logic [15:0]       mem_wd;

  always_ff @(posedge aclk) begin
    if (clk_en && mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
  end

  // ----------------------------------------------------------------
  // Burst and command engine
  // ----------------------------------------------------------------
  logic [3:0]        ws;
  logic [1:0]        bl;
  logic              async_mode;
  logic              rdy_pol;
  logic              link_edge;
  logic [4:0]        lead_sum;
  logic [3:0]        extra;
  logic [ADDR_W-1:0] nxt;
  logic [3:0]        grp_last;
  logic [SEC_W-1:0]  pick;
  logic [SEC_W-1:0]  cmd_sec;
  logic              valid;

  assign ws         = cfg[fbr_pkg::CFG_WS_LSB +: 4];
  assign bl         = cfg[fbr_pkg::CFG_BL_LSB +: 2];
  assign async_mode = cfg[fbr_pkg::CFG_ASYNC_BIT];
  assign rdy_pol    = cfg[fbr_pkg::CFG_RDYPOL_BIT];
  assign link_edge  = clk_s && !s_q.clk_prev;
  assign cmd_sec    = s_q.cmd_addr[MEM_AW-1:SEC_AW];

  always_comb begin
    pick = '0;
    for (int i = NSEC - 1; i >= 0; i--) begin
      if (s_q.ers_pend[i]) begin
        pick = SEC_W'(i);
      end
    end
  end

  always_comb begin
    s_d          = s_q;
    s_d.clk_prev = clk_s;
    mem_we       = 1'b0;
    mem_wa       = {s_q.ers_sec, s_q.ers_w};
    mem_wd       = fbr_pkg::ERASED_WORD;
    grp_last     = (bl == fbr_pkg::BL_WRAP8) ? fbr_pkg::GRP8_LAST : fbr_pkg::GRP16_LAST;
    lead_sum     = {2'b00, s_q.start_w} + {1'b0, ws};
    extra        = 4'h0;

    // Next word: plain increment wraps through zero, wrap modes stay in group
    if (bl == fbr_pkg::BL_CONT) begin
      nxt = s_q.addr + ADDR_W'(1);
    end else begin
      nxt = s_q.addr;
      nxt[3:0] = (s_q.addr[3:0] & ~grp_last) | ((s_q.addr[3:0] + 4'h1) & grp_last);
    end
    // Waits after word 7 of the first unit depend on start word and latency
    if (bl == fbr_pkg::BL_CONT && s_q.first && s_q.addr[2:0] == 3'h7 &&
        lead_sum > fbr_pkg::WS_PIVOT) begin
      extra = 4'(lead_sum - fbr_pkg::WS_PIVOT);
    end
    // Wrap modes never get here, their group sits inside one 128-word block
    if (bl == fbr_pkg::BL_CONT && &s_q.addr[fbr_pkg::BOUND_BITS-1:0]) begin
      extra = extra + ((ws == fbr_pkg::WS_MAX) ? fbr_pkg::BND_WAIT_HI
                                                : fbr_pkg::BND_WAIT_LO);
    end

    if (refuse_clr) begin
      s_d.refused = 1'b0;
    end

    // Erase sweep, one word per cycle, halted while suspended
    if (s_q.ers_act && !s_q.susp) begin
      mem_we    = 1'b1;
      s_d.ers_w = s_q.ers_w + SEC_AW'(1);
      if (&s_q.ers_w) begin
        s_d.ers_act               = 1'b0;
        s_d.ers_pend[s_q.ers_sec] = 1'b0;
      end
    end else if (!s_q.ers_act && |s_q.ers_pend) begin
      s_d.ers_act = 1'b1;
      s_d.ers_sec = pick;
      s_d.ers_w   = '0;
    end

    if (ce_n_s || !frst_n_s) begin
      s_d.st = fbr_pkg::ST_IDLE;
      if (!frst_n_s) begin
        s_d.ers_pend = '0;
        s_d.ers_act  = 1'b0;
        s_d.susp     = 1'b0;
        s_d.prog_arm = 1'b0;
      end
    end else if (link_edge) begin
      if (!avd_n_s && oe_n_s) begin
        // New address: ends any running burst and starts the next
        s_d.addr     = bus_addr_s;
        s_d.cmd_addr = bus_addr_s;
        s_d.start_w  = bus_addr_s[2:0];
        s_d.first    = 1'b1;
        s_d.left     = grp_last;
        s_d.cnt      = ws - 4'h1;
        s_d.st       = fbr_pkg::ST_LAT;
      end else if (!we_n_s && oe_n_s) begin
        // Command data phase; burst state is left alone on purpose
        if (s_q.prog_arm) begin
          s_d.prog_arm = 1'b0;
          if (s_q.ers_act && (!s_q.susp || cmd_sec == s_q.ers_sec)) begin
            s_d.refused = 1'b1;
          end else begin
            mem_we = 1'b1;
            mem_wa = s_q.cmd_addr[MEM_AW-1:0];
            mem_wd = mem[s_q.cmd_addr[MEM_AW-1:0]] & bus_addr_s[15:0];
          end
        end else begin
          case (bus_addr_s[7:0])
            fbr_pkg::CMD_PROG:       s_d.prog_arm = 1'b1;
            fbr_pkg::CMD_SEC_ERASE:  s_d.ers_pend[cmd_sec] = 1'b1;
            fbr_pkg::CMD_CHIP_ERASE: s_d.ers_pend = '1;
            fbr_pkg::CMD_SUSPEND:    s_d.susp = s_q.ers_act;
            fbr_pkg::CMD_RESUME:     s_d.susp = 1'b0;
            fbr_pkg::CMD_RESET:      s_d.prog_arm = 1'b0;
            default:                 s_d.prog_arm = 1'b0;
          endcase
        end
      end else begin
        case (s_q.st)
          fbr_pkg::ST_IDLE: begin
          end
          fbr_pkg::ST_LAT: begin
            if (s_q.cnt == 4'h0) begin
              s_d.st = fbr_pkg::ST_DATA;
            end else begin
              s_d.cnt = s_q.cnt - 4'h1;
            end
          end
          fbr_pkg::ST_DATA: begin
            // A word is taken only while output enable is low
            if (!oe_n_s && !async_mode) begin
              if (bl != fbr_pkg::BL_CONT && s_q.left == 4'h0) begin
                s_d.st = fbr_pkg::ST_IDLE;
              end else begin
                s_d.addr = nxt;
                s_d.left = s_q.left - 4'h1;
                if (s_q.addr[2:0] == 3'h7) begin
                  s_d.first = 1'b0;
                end
                if (extra != 4'h0) begin
                  s_d.cnt = extra - 4'h1;
                  s_d.st  = fbr_pkg::ST_WAIT;
                end
              end
            end
          end
          fbr_pkg::ST_WAIT: begin
            if (s_q.cnt == 4'h0) begin
              s_d.st = fbr_pkg::ST_DATA;
            end else begin
              s_d.cnt = s_q.cnt - 4'h1;
            end
          end
          default: s_d.st = fbr_pkg::ST_IDLE;
        endcase
      end
    end

    // Ready stays inactive through latency and every inserted wait
    valid       = s_d.st == fbr_pkg::ST_DATA && !oe_n_s && !ce_n_s;
    s_d.rdy     = rdy_pol ? valid : !valid;
    s_d.drive_n = !valid;
    s_d.dout    = mem[s_d.addr[MEM_AW-1:0]];
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q          <= '0;
      s_q.st       <= fbr_pkg::ST_IDLE;
      s_q.drive_n  <= 1'b1;
      // Array comes up erased; the sweep runs once after reset
      s_q.ers_pend <= '1;
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  assign adq_o    = s_q.dout;
  assign adq_oe_n = s_q.drive_n;
  assign rdy      = s_q.rdy;

endmodule
`default_nettype wire

// >>> core/fbr_pkg.sv
package fbr_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0]  REG_CFG        = 8'h00;
  localparam logic [7:0]  REG_STATUS     = 8'h04;
  localparam logic [7:0]  REG_ADDR       = 8'h08;
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;

  // ----------------------------------------------------------------
  // Configuration fields
  // ----------------------------------------------------------------
  localparam int          CFG_WS_LSB     = 0;
  localparam int          CFG_BL_LSB     = 4;
  localparam int          CFG_RDYPOL_BIT = 6;
  localparam int          CFG_ASYNC_BIT  = 15;
  localparam logic [15:0] CFG_RESET      = 16'h8047;
  localparam logic [15:0] CFG_MASK       = 16'h807f;
  localparam logic [3:0]  WS_MIN         = 4'h3;
  localparam logic [3:0]  WS_MAX         = 4'h9;
  localparam logic [4:0]  WS_PIVOT       = 5'h08;
  localparam logic [1:0]  BL_CONT        = 2'h0;
  localparam logic [1:0]  BL_WRAP8       = 2'h1;
  localparam logic [1:0]  BL_WRAP16      = 2'h2;
  localparam logic [3:0]  GRP8_LAST      = 4'h7;
  localparam logic [3:0]  GRP16_LAST     = 4'hf;
  localparam int          BOUND_BITS     = 7;
  localparam logic [3:0]  BND_WAIT_LO    = 4'h1;
  localparam logic [3:0]  BND_WAIT_HI    = 4'h2;

  // ----------------------------------------------------------------
  // Status fields
  // ----------------------------------------------------------------
  localparam int          ST_BURST_BIT   = 0;
  localparam int          ST_ERASE_BIT   = 1;
  localparam int          ST_SUSP_BIT    = 2;
  localparam int          ST_REFUSE_BIT  = 3;
  localparam int          ST_PEND_BIT    = 4;

  // ----------------------------------------------------------------
  // Command bytes and array constants
  // ----------------------------------------------------------------
  localparam logic [7:0]  CMD_RESET      = 8'hf0;
  localparam logic [7:0]  CMD_PROG       = 8'ha0;
  localparam logic [7:0]  CMD_SEC_ERASE  = 8'h30;
  localparam logic [7:0]  CMD_CHIP_ERASE = 8'h10;
  localparam logic [7:0]  CMD_SUSPEND    = 8'hb0;
  localparam logic [7:0]  CMD_RESUME     = 8'h50;
  localparam logic [15:0] ERASED_WORD    = 16'hffff;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_LAT  = 4'b0010,
    ST_DATA = 4'b0100,
    ST_WAIT = 4'b1000
  } fbr_state_e;

endpackage

// >>> core/fbr_sync.sv
`timescale 1ns/10ps
`default_nettype none
module fbr_sync #(
  parameter int          W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic         clk_en,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stab;
  } fbr_sync_s;

  fbr_sync_s s_q;
  fbr_sync_s s_d;

  // First stage feeds only the second stage
  always_comb begin
    s_d      = s_q;
    s_d.meta = d;
    s_d.stab = s_q.meta;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '{meta: RST_VAL, stab: RST_VAL};
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  assign q = s_q.stab;

endmodule
`default_nettype wire

// >>> core/fbr_axil.sv
`timescale 1ns/10ps
`default_nettype none
module fbr_axil #(
  parameter int AW = 8
) (
  input  wire logic          aclk,
  input  wire logic          aresetn,
  input  wire logic          clk_en,
  input  wire logic [AW-1:0] awaddr,
  input  wire logic          awvalid,
  output logic               awready,
  input  wire logic [31:0]   wdata,
  input  wire logic [3:0]    wstrb,
  input  wire logic          wvalid,
  output logic               wready,
  output logic [1:0]         bresp,
  output logic               bvalid,
  input  wire logic          bready,
  input  wire logic [AW-1:0] araddr,
  input  wire logic          arvalid,
  output logic               arready,
  output logic [31:0]        rdata,
  output logic [1:0]         rresp,
  output logic               rvalid,
  input  wire logic          rready,
  input  wire logic [31:0]   status_i,
  input  wire logic [31:0]   addr_i,
  output logic [15:0]        cfg_o,
  output logic               refuse_clr_o
);

  typedef struct packed {
    logic          aw_have;
    logic [AW-1:0] aw_addr;
    logic          w_have;
    logic [15:0]   w_data;
    logic [1:0]    w_strb;
    logic          awready;
    logic          wready;
    logic          bvalid;
    logic [1:0]    bresp;
    logic          arready;
    logic          rvalid;
    logic [31:0]   rdata;
    logic [1:0]    rresp;
    logic [15:0]   cfg;
    logic          refuse_clr;
  } fbr_axil_s;

  fbr_axil_s s_q;
  fbr_axil_s s_d;
  logic [15:0] cfg_new;

  always_comb begin
    s_d            = s_q;
    cfg_new        = s_q.cfg;
    s_d.refuse_clr = 1'b0;
    // ----------------------------------------------------------------
    // Write: address and data taken in either order
    // ----------------------------------------------------------------
    if (awvalid && s_q.awready) begin
      s_d.aw_have = 1'b1;
      s_d.aw_addr = awaddr;
    end
    if (wvalid && s_q.wready) begin
      s_d.w_have = 1'b1;
      s_d.w_data = wdata[15:0];
      s_d.w_strb = wstrb[1:0];
    end
    if (s_q.bvalid && bready) begin
      s_d.bvalid = 1'b0;
    end
    if (s_q.aw_have && s_q.w_have && !s_q.bvalid) begin
      s_d.aw_have = 1'b0;
      s_d.w_have  = 1'b0;
      s_d.bvalid  = 1'b1;
      s_d.bresp   = fbr_pkg::RESP_OKAY;
      case (s_q.aw_addr)
        AW'(fbr_pkg::REG_CFG): begin
          if (s_q.w_strb[0]) begin
            cfg_new[7:0] = s_q.w_data[7:0];
          end
          if (s_q.w_strb[1]) begin
            cfg_new[15:8] = s_q.w_data[15:8];
          end
          cfg_new = cfg_new & fbr_pkg::CFG_MASK;
          // Out-of-range latency saturates into the legal window
          if (cfg_new[fbr_pkg::CFG_WS_LSB +: 4] < fbr_pkg::WS_MIN) begin
            cfg_new[fbr_pkg::CFG_WS_LSB +: 4] = fbr_pkg::WS_MIN;
          end else if (cfg_new[fbr_pkg::CFG_WS_LSB +: 4] > fbr_pkg::WS_MAX) begin
            cfg_new[fbr_pkg::CFG_WS_LSB +: 4] = fbr_pkg::WS_MAX;
          end
          s_d.cfg = cfg_new;
        end
        AW'(fbr_pkg::REG_STATUS): begin
          s_d.refuse_clr = s_q.w_strb[0] && s_q.w_data[fbr_pkg::ST_REFUSE_BIT];
        end
        AW'(fbr_pkg::REG_ADDR): begin
        end
        default: begin
          s_d.bresp = fbr_pkg::RESP_SLVERR;
        end
      endcase
    end
    s_d.awready = !s_d.aw_have && !s_d.bvalid;
    s_d.wready  = !s_d.w_have && !s_d.bvalid;
    // ----------------------------------------------------------------
    // Read
    // ----------------------------------------------------------------
    if (s_q.rvalid && rready) begin
      s_d.rvalid = 1'b0;
    end
    if (arvalid && s_q.arready) begin
      s_d.rvalid = 1'b1;
      s_d.rresp  = fbr_pkg::RESP_OKAY;
      case (araddr)
        AW'(fbr_pkg::REG_CFG):    s_d.rdata = {16'h0000, s_q.cfg};
        AW'(fbr_pkg::REG_STATUS): s_d.rdata = status_i;
        AW'(fbr_pkg::REG_ADDR):   s_d.rdata = addr_i;
        default: begin
          s_d.rdata = 32'h0000_0000;
          s_d.rresp = fbr_pkg::RESP_SLVERR;
        end
      endcase
    end
    s_d.arready = !s_d.rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q         <= '0;
      s_q.cfg     <= fbr_pkg::CFG_RESET;
      s_q.awready <= 1'b1;
      s_q.wready  <= 1'b1;
      s_q.arready <= 1'b1;
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  assign awready      = s_q.awready;
  assign wready       = s_q.wready;
  assign bvalid       = s_q.bvalid;
  assign bresp        = s_q.bresp;
  assign arready      = s_q.arready;
  assign rvalid       = s_q.rvalid;
  assign rdata        = s_q.rdata;
  assign rresp        = s_q.rresp;
  assign cfg_o        = s_q.cfg;
  assign refuse_clr_o = s_q.refuse_clr;

endmodule
`default_nettype wire

// >>> verif/fbr_burst_seq_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module fbr_burst_seq_assertions (
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       chip_en_n,
  input wire logic       out_en_n,
  input wire logic       flash_reset_n,
  input wire logic       adq_oe_n,
  input wire logic       awvalid,
  input wire logic       awready,
  input wire logic       wvalid,
  input wire logic       wready,
  input wire logic       bvalid,
  input wire logic       bready,
  input wire logic [1:0] bresp,
  input wire logic       arvalid,
  input wire logic       arready,
  input wire logic       rvalid,
  input wire logic       rready
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Six cycles cover the pin synchronisers and the output register
  sequence s_oe_off; out_en_n [*6]; endsequence
  sequence s_wr_taken; awvalid && awready && wvalid && wready; endsequence
  a_oe_release: assert property (s_oe_off |-> adq_oe_n)
    else $error("bus driven with output enable high");
  a_ce_ends: assert property (chip_en_n [*6] |-> adq_oe_n)
    else $error("bus driven with chip enable high");
  a_pin_reset_ends: assert property (!flash_reset_n [*6] |-> adq_oe_n)
    else $error("bus driven during pin reset");
  a_write_answer: assert property (s_wr_taken |-> ##[1:2] bvalid)
    else $error("write response late");
  a_bresp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");
  a_write_lock: assert property (bvalid |-> !awready && !wready)
    else $error("write taken while response pending");
  a_read_answer: assert property (arvalid && arready |=> rvalid)
    else $error("read data late");
  a_rvalid_hold: assert property (rvalid && !rready |=> rvalid && !arready)
    else $error("read data dropped");
endmodule
bind fbr_burst_seq fbr_burst_seq_assertions u_chk (.aclk(aclk), .aresetn(aresetn),
  .chip_en_n(chip_en_n), .out_en_n(out_en_n), .flash_reset_n(flash_reset_n),
  .adq_oe_n(adq_oe_n), .awvalid(awvalid), .awready(awready), .wvalid(wvalid),
  .wready(wready), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
  .arready(arready), .rvalid(rvalid), .rready(rready));
`default_nettype wire

// >>> verif/fbr_host.sv
`timescale 1ns/10ps
`default_nettype none
module fbr_host (
  input  wire logic        aclk,
  input  wire logic [15:0] adq_o,
  input  wire logic        adq_oe_n,
  input  wire logic        rdy,
  output logic             burst_clk,
  output logic             chip_en_n,
  output logic             address_valid_n,
  output logic             out_en_n,
  output logic             write_en_n,
  output logic             flash_reset_n,
  output logic [5:0]       addr_hi,
  output logic [15:0]      adq_i
);
  logic [15:0] drv = '0;
  logic        drv_en = 1'b0;
  initial {burst_clk, chip_en_n, address_valid_n, out_en_n, write_en_n, flash_reset_n} = 6'h1f;
  initial {addr_hi, adq_i} = '0;
  // A released bus flips each cycle so a stale word never looks fresh
  always @(posedge aclk)
    adq_i <= !adq_oe_n ? adq_o : drv_en ? drv : ~adq_i;
  // One link cycle of 8 aclk; the link clock only runs inside it
  task automatic cyc(input logic [4:0] ctl, input logic [21:0] a, output logic [1:0] r);
    @(posedge aclk);
    {flash_reset_n, chip_en_n, address_valid_n, out_en_n, write_en_n} <= ctl;
    {addr_hi, drv} <= a;
    drv_en <= ctl[1];
    repeat (2) @(posedge aclk);
    burst_clk <= 1'b1;
    repeat (4) @(posedge aclk);
    burst_clk <= 1'b0;
    repeat (2) @(negedge aclk);
    r = {rdy, !adq_oe_n};
  endtask
endmodule
`default_nettype wire

// >>> verif/fbr_burst_seq_tb.sv
`timescale 1ns/10ps
`default_nettype none
module fbr_burst_seq_tb;
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic [7:0]  awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata, q;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, rdy, adq_oe_n, burst_clk;
  logic        chip_en_n, address_valid_n, out_en_n, write_en_n, flash_reset_n;
  logic [1:0]  bresp, rresp, rsp;
  logic [15:0] adq_i, adq_o;
  logic [5:0]  addr_hi;
  int          miscompares = 0, checks_done = 0;
  always #20 aclk = ~aclk;
  fbr_host u_host (.aclk(aclk), .adq_o(adq_o), .adq_oe_n(adq_oe_n), .rdy(rdy),
    .burst_clk(burst_clk), .chip_en_n(chip_en_n), .address_valid_n(address_valid_n),
    .out_en_n(out_en_n), .write_en_n(write_en_n), .flash_reset_n(flash_reset_n),
    .addr_hi(addr_hi), .adq_i(adq_i));
  fbr_burst_seq u_dut (.aclk(aclk), .aresetn(aresetn), .clk_en(1'b1), .burst_clk(burst_clk),
    .chip_en_n(chip_en_n), .address_valid_n(address_valid_n), .out_en_n(out_en_n),
    .write_en_n(write_en_n), .flash_reset_n(flash_reset_n), .addr_hi_i(addr_hi),
    .adq_i(adq_i), .adq_o(adq_o), .adq_oe_n(adq_oe_n), .rdy(rdy), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready));
  task automatic chk(input logic ok, input string m);
    checks_done++;
    if (!ok) begin
      miscompares++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask
  task automatic axi(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    {awaddr, araddr, wdata} <= {a, a, d};
    {awvalid, wvalid, bready, arvalid, rready} <= {{3{wr}}, {2{!wr}}};
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (arready) arvalid <= 1'b0;
      if (bvalid || rvalid) begin
        {bready, rready} <= 2'b00;
        q = rdata;
        rsp = wr ? bresp : rresp;
      end
    end while (awvalid || wvalid || bready || arvalid || rready);
  endtask
  task automatic t_regs;
    axi(1'b0, fbr_pkg::REG_CFG, '0);
    chk(q[15:0] === fbr_pkg::CFG_RESET, "config reset value");
    axi(1'b0, 8'h0c, '0);
    chk(rsp === fbr_pkg::RESP_SLVERR, "unmapped offset");
    axi(1'b1, fbr_pkg::REG_CFG, 32'h42);
    axi(1'b0, fbr_pkg::REG_CFG, '0);
    chk(q[3:0] === fbr_pkg::WS_MIN, "latency low clamp");
    axi(1'b1, fbr_pkg::REG_CFG, 32'h4f);
    axi(1'b0, fbr_pkg::REG_CFG, '0);
    chk(q[3:0] === fbr_pkg::WS_MAX, "latency high clamp");
  endtask
  task automatic t_prog;
    logic [1:0] r;
    axi(1'b1, fbr_pkg::REG_CFG, 32'h43);
    u_host.cyc(5'b10011, 22'h5, r);
    u_host.cyc(5'b10110, {14'h0, fbr_pkg::CMD_PROG}, r);
    u_host.cyc(5'b10011, 22'h5, r);
    u_host.cyc(5'b10110, 22'h1234, r);
    u_host.cyc(5'b10011, 22'h5, r);
    repeat (3) u_host.cyc(5'b10001, 22'h5, r);
    chk(r === 2'b11 && adq_o === 16'h1234, "programmed word");
    u_host.cyc(5'b11111, 22'h5, r);
  endtask
  task automatic t_burst(input int w, input logic [21:0] a, input logic [1:0] bl, input logic cmd);
    logic [1:0] r;
    logic       v;
    int         s, wt, len, n, j;
    s = int'(a[2:0]);
    wt = (s + w > 8 ? s + w - 8 : 0) + (a[6:3] == 4'hf ? (w == 9 ? 2 : 1) : 0);
    len = bl == 2'h1 ? 8 : 16;
    n = bl == 2'h0 ? w + 10 - s + wt : w + len + 2;
    axi(1'b1, fbr_pkg::REG_CFG, {26'h1, bl, w[3:0]});
    u_host.cyc(5'b10011, a, r);
    for (int k = 1; k <= n + int'(cmd); k++) begin
      if (cmd && k == 1) begin
        u_host.cyc(5'b10110, {14'h0, fbr_pkg::CMD_RESET}, r);
        continue;
      end
      // A command edge stalls the latency count, so every slot shifts by one
      j = k - int'(cmd);
      u_host.cyc(5'b10001, a, r);
      v = j >= w && (bl != 2'h0 ? j - w < len : j - w < 8 - s || j - w >= 8 - s + wt);
      chk(r === {v, v}, "word or wait slot");
    end
    u_host.cyc(5'b11111, a, r);
  endtask
  task automatic t_term(input logic pin);
    logic [1:0] r;
    axi(1'b1, fbr_pkg::REG_CFG, 32'h43);
    u_host.cyc(5'b10011, '0, r);
    repeat (4) u_host.cyc(5'b10001, '0, r);
    chk(r === 2'b11, "burst not running");
    u_host.cyc(pin ? 5'b00101 : 5'b11101, '0, r);
    repeat (2) u_host.cyc(5'b10001, '0, r);
    chk(r === 2'b00, "burst not ended");
  endtask
  task automatic conclude;
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (1100) @(posedge aclk);
    t_regs();
    t_prog();
    for (int w = 3; w <= 9; w++)
      for (int s = 0; s < 16; s++)
        t_burst(w, {15'h0, {4{s[3]}}, s[2:0]}, 2'h0, 1'b0);
    t_burst(3, 22'h3a, 2'h1, 1'b0);
    t_burst(9, 22'h7e, 2'h2, 1'b0);
    t_burst(3, 22'h0, 2'h0, 1'b1);
    t_term(1'b0);
    t_term(1'b1);
    conclude();
  end
  initial begin
    repeat (60000) @(posedge aclk);
    miscompares++;
    conclude();
  end
endmodule
`default_nettype wire
